// file: codec_irq_defines.svh
// Constants for the host status and interrupt block.
// Assumes inclusion by bare name from the package and the design.
`ifndef CODEC_IRQ_DEFINES_SVH
`define CODEC_IRQ_DEFINES_SVH

// -----------------------------------------------------------------------------
// Mask and status bit positions, source count and reset values
// -----------------------------------------------------------------------------
`define IRQ_BIT_HALT 0
`define IRQ_BIT_SERVICE 1
`define IRQ_BIT_ERROR 2
`define IRQ_BIT_FINAL 3
`define IRQ_BIT_STATS 4
`define IRQ_BIT_LINK 5
`define IRQ_NUM_SRC 6
`define IRQ_MASK_RESET 6'h00
`define IRQ_POL_RESET 1'h0

`endif

// file: codec_irq_pkg.sv
// Types shared by the host status and interrupt block.
// Assumes the defines header is on the include path.
`include "codec_irq_defines.svh"

package codec_irq_pkg;

	// FIFO condition inputs from the compressed-data queue
	typedef struct packed {
		logic empty;
		logic full;
		logic nearly_full;
		logic nearly_empty;
		logic overflow;
		logic underflow;
	} queue_cond_t;

	// Status vector, one bit per interrupt source
	typedef logic [`IRQ_NUM_SRC-1:0] irq_vec_t;

	typedef enum logic [0:0] {
		MODE_ENCODE = 1'b0,
		MODE_DECODE = 1'b1
	} codec_mode_t;

endpackage : codec_irq_pkg

// file: codec_host_status_irq.sv
// Host status pins, mask/status register and host interrupt of the codec.
// Assumes all inputs are synchronous to sys_clk_in; the host writes the
// mask and polarity as plain ports.
`include "codec_irq_defines.svh"

module codec_host_status_irq (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire codec_irq_pkg::codec_mode_t mode_in,
	input wire codec_irq_pkg::queue_cond_t queue_in,
	input wire logic stats_updated_in,
	input wire logic stats_read_in,
	input wire logic field_last_pending_in,
	input wire logic link_error_in,
	input wire codec_irq_pkg::irq_vec_t irq_mask_in,
	input wire logic irq_mask_we_in,
	input wire logic irq_polarity_in,
	input wire logic irq_polarity_we_in,
	output logic fifo_halt_flag_out,
	output logic queue_service_pin_out,
	output logic queue_error_pin_out,
	output logic statistics_valid_pin_out,
	output logic field_final_word_flag_out,
	output codec_irq_pkg::irq_vec_t irq_status_out,
	output codec_irq_pkg::irq_vec_t irq_mask_out,
	output logic irq_polarity_out,
	output logic host_irq_pin_out
);
	import codec_irq_pkg::*;

	// -------------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------------
	irq_vec_t status;
	irq_vec_t next_status;
	irq_vec_t mask;
	irq_vec_t next_mask;
	logic polarity;
	logic next_polarity;
	logic stats_valid;
	logic next_stats_valid;
	logic irq_pin;
	logic next_irq_pin;
	logic halt_now;
	logic service_now;
	logic error_now;

	// -------------------------------------------------------------------------
	// FIFO conditions for the current direction
	// -------------------------------------------------------------------------
	always_comb begin
		halt_now = queue_in.full;
		service_now = queue_in.nearly_empty;
		error_now = queue_in.underflow;
		// Encode drains the queue to the host, decode fills it
		if (mode_in == MODE_ENCODE) begin
			halt_now = queue_in.empty;
			service_now = queue_in.nearly_full;
			error_now = queue_in.overflow;
		end
	end

	// -------------------------------------------------------------------------
	// Statistics-valid latch
	// -------------------------------------------------------------------------
	always_comb begin
		next_stats_valid = stats_valid;
		// Set wins over a read in the same cycle; one event per field
		if (stats_updated_in) begin
			next_stats_valid = 1'b1;
		end else if (stats_read_in) begin
			next_stats_valid = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			stats_valid <= 1'b0;
		end else begin
			stats_valid <= next_stats_valid;
		end
	end

	// -------------------------------------------------------------------------
	// Status register
	// -------------------------------------------------------------------------
	always_comb begin
		next_status = '0;
		next_status[`IRQ_BIT_HALT] = halt_now;
		next_status[`IRQ_BIT_SERVICE] = service_now;
		next_status[`IRQ_BIT_ERROR] = error_now;
		next_status[`IRQ_BIT_FINAL] = field_last_pending_in;
		next_status[`IRQ_BIT_STATS] = next_stats_valid;
		next_status[`IRQ_BIT_LINK] = link_error_in;
	end

	// Pins are registered, so status and pins always agree
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	// -------------------------------------------------------------------------
	// Mask and polarity
	// -------------------------------------------------------------------------
	always_comb begin
		next_mask = mask;
		next_polarity = polarity;
		if (irq_mask_we_in) begin
			next_mask = irq_mask_in;
		end
		if (irq_polarity_we_in) begin
			next_polarity = irq_polarity_in;
		end
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			mask <= `IRQ_MASK_RESET;
			polarity <= `IRQ_POL_RESET;
		end else begin
			mask <= next_mask;
			polarity <= next_polarity;
		end
	end

	// -------------------------------------------------------------------------
	// Host interrupt pin
	// -------------------------------------------------------------------------
	// Built from next values: moves with status, free of glitches
	always_comb begin
		next_irq_pin = |(next_status & next_mask);
		next_irq_pin = next_irq_pin ^ next_polarity;
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			// Idle level of the pin is the reset polarity
			irq_pin <= `IRQ_POL_RESET;
		end else begin
			irq_pin <= next_irq_pin;
		end
	end

	// -------------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------------
	assign host_irq_pin_out = irq_pin;
	assign fifo_halt_flag_out = status[`IRQ_BIT_HALT];
	assign queue_service_pin_out = status[`IRQ_BIT_SERVICE];
	assign queue_error_pin_out = status[`IRQ_BIT_ERROR];
	assign statistics_valid_pin_out = status[`IRQ_BIT_STATS];
	assign field_final_word_flag_out = status[`IRQ_BIT_FINAL];
	assign irq_status_out = status;
	assign irq_mask_out = mask;
	assign irq_polarity_out = polarity;

	// -------------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------------
	a_halt_encode: assert property (@(posedge sys_clk_in)
		disable iff (reset_in) (mode_in == MODE_ENCODE) |=>
		fifo_halt_flag_out == $past(queue_in.empty))
		else $error("halt flag wrong in encode");
	a_halt_decode: assert property (@(posedge sys_clk_in)
		disable iff (reset_in) (mode_in == MODE_DECODE) |=>
		fifo_halt_flag_out == $past(queue_in.full))
		else $error("halt flag wrong in decode");
	a_status_mirror: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		irq_status_out[`IRQ_BIT_STATS] == statistics_valid_pin_out &&
		irq_status_out[`IRQ_BIT_HALT] == fifo_halt_flag_out)
		else $error("status register not mirroring pins");
	a_status_track: assert property (@(posedge sys_clk_in)
		disable iff (reset_in) 1'b1 |=>
		irq_status_out[`IRQ_BIT_FINAL] == $past(field_last_pending_in))
		else $error("status final bit not tracking");
	a_stats_rise: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		stats_updated_in |=> statistics_valid_pin_out)
		else $error("stats pin missed update");
	a_stats_clear: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		(stats_read_in && !stats_updated_in) |=> !statistics_valid_pin_out)
		else $error("stats pin not cleared by read");
	a_stats_keep: assert property (@(posedge sys_clk_in)
		disable iff (reset_in) (!stats_read_in && !stats_updated_in) |=>
		$stable(statistics_valid_pin_out))
		else $error("stats pin changed without event");
	a_stats_hold: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		$rose(statistics_valid_pin_out) |-> $past(stats_updated_in))
		else $error("stats pin rose without field update");
	a_final_word: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		field_last_pending_in |=> field_final_word_flag_out)
		else $error("final word flag late");
	a_final_clear: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		!field_last_pending_in |=> !field_final_word_flag_out)
		else $error("final word flag without pending word");
	a_irq_combine: assert property (@(posedge sys_clk_in)
		disable iff (reset_in) host_irq_pin_out ==
		((|(irq_status_out & irq_mask_out)) ^ irq_polarity_out))
		else $error("host interrupt wrong");
	a_irq_enabled: assert property (@(posedge sys_clk_in)
		disable iff (reset_in) ((irq_status_out & irq_mask_out) != '0) |->
		(host_irq_pin_out != irq_polarity_out))
		else $error("enabled source did not raise interrupt");
	a_link_status: assert property (@(posedge sys_clk_in)
		disable iff (reset_in) 1'b1 |=>
		irq_status_out[`IRQ_BIT_LINK] == $past(link_error_in))
		else $error("link error source not tracking");
	a_polarity_take: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		irq_polarity_we_in |=> irq_polarity_out == $past(irq_polarity_in))
		else $error("polarity not taken");
	a_error_pin: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		(mode_in == MODE_DECODE && queue_in.underflow) |=> queue_error_pin_out)
		else $error("error pin missed underflow");
	a_error_encode: assert property (@(posedge sys_clk_in)
		disable iff (reset_in) (mode_in == MODE_ENCODE) |=>
		queue_error_pin_out == $past(queue_in.overflow))
		else $error("error pin wrong in encode");
	a_service_pin: assert property (@(posedge sys_clk_in)
		disable iff (reset_in) (mode_in == MODE_ENCODE) |=>
		queue_service_pin_out == $past(queue_in.nearly_full))
		else $error("service pin wrong in encode");
	a_service_decode: assert property (@(posedge sys_clk_in)
		disable iff (reset_in) (mode_in == MODE_DECODE) |=>
		queue_service_pin_out == $past(queue_in.nearly_empty))
		else $error("service pin wrong in decode");
	a_mask_gate: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		(irq_mask_out == '0) |-> host_irq_pin_out == irq_polarity_out)
		else $error("interrupt raised with all masked");
	a_mask_take: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		irq_mask_we_in |=> irq_mask_out == $past(irq_mask_in))
		else $error("mask not taken");

endmodule : codec_host_status_irq

// file: host_model.sv
// Host model: writes mask and polarity, reads statistics on interrupt.
// Assumes the bench seeds the random generator and drives reset.
module host_model (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic irq_in,
	output codec_irq_pkg::irq_vec_t mask_out,
	output logic mask_we_out,
	output logic pol_out,
	output logic pol_we_out,
	output logic read_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import codec_irq_pkg::*;
	always @(posedge clk_in) begin
		if (reset_in) begin
			{mask_out, mask_we_out, pol_out, pol_we_out, read_out} <= '0;
		end else begin
			mask_out <= irq_vec_t'($urandom);
			mask_we_out <= ($urandom % 5 == 0);
			pol_out <= 1'($urandom);
			pol_we_out <= ($urandom % 9 == 0);
			// Services a raised interrupt only some of the time
			read_out <= irq_in && 1'($urandom);
		end
	end
endmodule : host_model

// file: testbench.sv
// Bench for the host status and interrupt block, random traffic.
// Assumes the design package and the host model are compiled first.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import codec_irq_pkg::*;
	logic sys_clk_in = 0, reset_in = 1, stats_updated_in = 0;
	logic field_last_pending_in = 0, link_error_in = 0;
	codec_mode_t mode_in = MODE_ENCODE;
	queue_cond_t queue_in = '0;
	irq_vec_t irq_mask_in, irq_status_out, irq_mask_out;
	logic irq_mask_we_in, irq_polarity_in, irq_polarity_we_in;
	logic stats_read_in, fifo_halt_flag_out, queue_service_pin_out;
	logic queue_error_pin_out, statistics_valid_pin_out;
	logic field_final_word_flag_out, irq_polarity_out, host_irq_pin_out;
	int num_errors = 0, check_count = 0;
	logic [12:0] exq[$];
	logic [12:0] e;
	irq_vec_t s_e, m_e = '0;
	logic p_e = 0, sv = 0;
	logic [18:0] all_out;
	codec_host_status_irq uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.mode_in(mode_in), .queue_in(queue_in),
		.stats_updated_in(stats_updated_in), .stats_read_in(stats_read_in),
		.field_last_pending_in(field_last_pending_in),
		.link_error_in(link_error_in), .irq_mask_in(irq_mask_in),
		.irq_mask_we_in(irq_mask_we_in), .irq_polarity_in(irq_polarity_in),
		.irq_polarity_we_in(irq_polarity_we_in),
		.fifo_halt_flag_out(fifo_halt_flag_out),
		.queue_service_pin_out(queue_service_pin_out),
		.queue_error_pin_out(queue_error_pin_out),
		.statistics_valid_pin_out(statistics_valid_pin_out),
		.field_final_word_flag_out(field_final_word_flag_out),
		.irq_status_out(irq_status_out), .irq_mask_out(irq_mask_out),
		.irq_polarity_out(irq_polarity_out),
		.host_irq_pin_out(host_irq_pin_out));
	assign all_out = {irq_status_out, irq_mask_out, irq_polarity_out,
		host_irq_pin_out, fifo_halt_flag_out, queue_service_pin_out,
		queue_error_pin_out, statistics_valid_pin_out,
		field_final_word_flag_out};
	host_model host (.clk_in(sys_clk_in), .reset_in(reset_in),
		.irq_in(host_irq_pin_out), .mask_out(irq_mask_in),
		.mask_we_out(irq_mask_we_in), .pol_out(irq_polarity_in),
		.pol_we_out(irq_polarity_we_in), .read_out(stats_read_in));
	always #12.5 sys_clk_in = ~sys_clk_in;
	// Predictor sees the inputs the design samples at this edge
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			{m_e, p_e, sv} = '0;
			exq.delete();
		end else begin
			s_e[0] = mode_in ? queue_in.full : queue_in.empty;
			s_e[1] = mode_in ? queue_in.nearly_empty : queue_in.nearly_full;
			s_e[2] = mode_in ? queue_in.underflow : queue_in.overflow;
			s_e[3] = field_last_pending_in;
			sv = stats_updated_in | (sv & !stats_read_in);
			s_e[4] = sv;
			s_e[5] = link_error_in;
			if (irq_mask_we_in) m_e = irq_mask_in;
			if (irq_polarity_we_in) p_e = irq_polarity_in;
			exq.push_back({s_e, m_e, p_e});
		end
	end
	always @(negedge sys_clk_in) begin
		if (reset_in) begin
			`CHK("reset", 19'h0, all_out)
		end else if (exq.size() > 0) begin
			e = exq.pop_front();
			`CHK("status", e[12:7], irq_status_out)
			`CHK("halt", e[7], fifo_halt_flag_out)
			`CHK("service", e[8], queue_service_pin_out)
			`CHK("error", e[9], queue_error_pin_out)
			`CHK("final", e[10], field_final_word_flag_out)
			`CHK("stats", e[11], statistics_valid_pin_out)
			`CHK("mask", e[6:1], irq_mask_out)
			`CHK("polarity", e[0], irq_polarity_out)
			`CHK("irq", (|(e[12:7] & e[6:1])) ^ e[0], host_irq_pin_out)
		end
	end
	task automatic run(input int n);
		repeat (n) @(posedge sys_clk_in) begin
			mode_in <= codec_mode_t'($urandom);
			queue_in <= queue_cond_t'($urandom);
			field_last_pending_in <= 1'($urandom);
			link_error_in <= 1'($urandom);
			stats_updated_in <= ($urandom % 16 == 0);
		end
	endtask : run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	initial begin
		void'($urandom(32'h1960657b));
		repeat (5) @(posedge sys_clk_in);
		reset_in <= 0;
		run(800);
		$display("test random_traffic done");
		reset_in <= 1;
		run(3);
		reset_in <= 0;
		run(800);
		$display("test reset_mid_run done");
		stop_test();
	end
endmodule : testbench
